// [rtl/cti_map.vh]
// Address map, field positions and reset values of the camera trigger and ROI registers.
// Assumes quadlet (32-bit) accesses with 48-bit node-relative addresses.
// Overview of operation
// R1: trigger on/off bit, off after reset
// R2: trigger polarity bit, active low after reset
// R3: source 0-3 external inputs, 7 software trigger
// R4: trigger mode 0 programmable, 1 level default
// R5: host pairs software source with mode 0
// R6: trigger parameter field written is ignored
// R7: software trigger write 1; self-clears in mode 0
// R8: max extent 656 by 491 mono, 490 colour
// R9: VGA sub-image centred in full image
// R10: size step 1 mono, 2 colour
// R11: position step 1 mono, 2 colour
// R12: reset origin (0,0), extent at maxima
// R13: format resets mono8 mono, YUV422 colour
// R14: mono takes 0,5; colour takes 0,9,10,2
// R15: second format capability word is unused
// R16: pixel count follows current ROI extent
// R17: frame bytes from extent and format, padded
// R18: payload granule 4, ceiling, suggested 4092
// R19: packets per frame from bytes and payload
// R20: host keeps packets per frame within 4095
// R21: data depth per format: 8/8,10/16,8/16
// R22: mosaic order code 0..3 reported
// R23: image registers at node-relative base
`ifndef CTI_MAP_VH
`define CTI_MAP_VH
`define CTI_M0_BASE 48'hffff_f1f0_0000
`define CTI_CSR_BASE 48'hffff_f0f0_0000
`define CTI_OFS_MAX_EXT 12'h000
`define CTI_OFS_SIZE_STEP 12'h004
`define CTI_OFS_ORIGIN 12'h008
`define CTI_OFS_EXTENT 12'h00c
`define CTI_OFS_FMT_SEL 12'h010
`define CTI_OFS_FMT_CAPS 12'h014
`define CTI_OFS_FMT_CAPS_EXT 12'h024
`define CTI_OFS_PIX_COUNT 12'h034
`define CTI_OFS_BYTES_HI 12'h038
`define CTI_OFS_BYTES_LO 12'h03c
`define CTI_OFS_PKT_LIMITS 12'h040
`define CTI_OFS_PAYLOAD 12'h044
`define CTI_OFS_PKT_COUNT 12'h048
`define CTI_OFS_POS_STEP 12'h04c
`define CTI_OFS_BIT_COUNT 12'h054
`define CTI_OFS_MOSAIC 12'h058
`define CTI_OFS_SW_TRIG 12'h62c
`define CTI_OFS_TRIG_CTRL 12'h830
`define CTI_HMAX 16'h0290
`define CTI_VMAX_MONO 16'h01eb
`define CTI_VMAX_COLOR 16'h01ea
`define CTI_VGA_W 16'h0280
`define CTI_VGA_H 16'h01e0
`define CTI_FMT_MONO8 8'h00
`define CTI_FMT_YUV422 8'h02
`define CTI_FMT_MONO16 8'h05
`define CTI_FMT_RAW8 8'h09
`define CTI_FMT_RAW16 8'h0a
`define CTI_PAYLOAD_GRANULE 16'h0004
`define CTI_PAYLOAD_SUGGESTED 16'h0ffc
`define CTI_SRC_SOFTWARE 3'h7
`define CTI_TRIG_EN_RST 1'b0
`define CTI_TRIG_POL_RST 1'b0
`define CTI_TRIG_SRC_RST 3'h0
`define CTI_TRIG_MODE_RST 1'b1
`define CTI_TRIG_PRESENT_BIT 31
`define CTI_TRIG_EN_BIT 25
`define CTI_TRIG_POL_BIT 24
`define CTI_TRIG_VALUE_BIT 20
`define CTI_TRIG_MODE_BIT 16
`define CTI_SW_TRIG_BIT 31
`endif

// [rtl/cti_regs.v]
// Trigger feature and scalable mode-zero image control registers of the camera.
// Assumes a link layer handing over one quadlet request at a time on clk and
// external trigger pins that are asynchronous to clk.
`timescale 1ns/10ps
`include "cti_map.vh"

module cti_regs #(
  parameter COLOR = 0,
  parameter MOSAIC_ORDER = 0,
  parameter EXTRA_BYTES = 0
) (
  input wire clk,
  input wire reset_n,
  input wire quad_req,
  input wire quad_write,
  input wire [47:0] quad_addr,
  input wire [31:0] quad_wdata,
  output reg quad_ack,
  output reg quad_err,
  output reg [31:0] quad_rdata,
  input wire [3:0] external_trigger_input,
  output reg exposure_start,
  output reg exposure_gate,
  output reg trigger_in_use,
  output reg [15:0] roi_left,
  output reg [15:0] roi_top,
  output reg [15:0] roi_width,
  output reg [15:0] roi_height,
  output reg [15:0] vga_left,
  output reg [15:0] vga_top,
  output reg [7:0] pixel_format,
  output reg [15:0] payload_setting,
  output reg [31:0] frame_packets
);

  localparam [15:0] VMAX = COLOR ? `CTI_VMAX_COLOR : `CTI_VMAX_MONO;
  localparam [15:0] UNIT = COLOR ? 16'h0002 : 16'h0001;
  localparam [7:0] FMT_RST = COLOR ? `CTI_FMT_YUV422 : `CTI_FMT_MONO8;
  localparam [4:0] A_NONE = 5'h00;
  localparam [4:0] A_MAX = 5'h01;
  localparam [4:0] A_SSTEP = 5'h02;
  localparam [4:0] A_ORIG = 5'h03;
  localparam [4:0] A_EXT = 5'h04;
  localparam [4:0] A_FMT = 5'h05;
  localparam [4:0] A_CAPS = 5'h06;
  localparam [4:0] A_CAPS2 = 5'h07;
  localparam [4:0] A_PIX = 5'h08;
  localparam [4:0] A_BHI = 5'h09;
  localparam [4:0] A_BLO = 5'h0a;
  localparam [4:0] A_PLIM = 5'h0b;
  localparam [4:0] A_PAY = 5'h0c;
  localparam [4:0] A_PKT = 5'h0d;
  localparam [4:0] A_PSTEP = 5'h0e;
  localparam [4:0] A_BITS = 5'h0f;
  localparam [4:0] A_MOS = 5'h10;
  localparam [4:0] A_SWT = 5'h11;
  localparam [4:0] A_TRIG = 5'h12;

  // address decode, shared by read and write paths
  function [4:0] decode;
    input [47:0] a;
    begin
      decode = A_NONE;
      if (a[47:12] == `CTI_M0_BASE >> 12) begin // R23
        case (a[11:0])
          `CTI_OFS_MAX_EXT: decode = A_MAX;
          `CTI_OFS_SIZE_STEP: decode = A_SSTEP;
          `CTI_OFS_ORIGIN: decode = A_ORIG;
          `CTI_OFS_EXTENT: decode = A_EXT;
          `CTI_OFS_FMT_SEL: decode = A_FMT;
          `CTI_OFS_FMT_CAPS: decode = A_CAPS;
          `CTI_OFS_FMT_CAPS_EXT: decode = A_CAPS2;
          `CTI_OFS_PIX_COUNT: decode = A_PIX;
          `CTI_OFS_BYTES_HI: decode = A_BHI;
          `CTI_OFS_BYTES_LO: decode = A_BLO;
          `CTI_OFS_PKT_LIMITS: decode = A_PLIM;
          `CTI_OFS_PAYLOAD: decode = A_PAY;
          `CTI_OFS_PKT_COUNT: decode = A_PKT;
          `CTI_OFS_POS_STEP: decode = A_PSTEP;
          `CTI_OFS_BIT_COUNT: decode = A_BITS;
          `CTI_OFS_MOSAIC: decode = A_MOS;
          default: decode = A_NONE;
        endcase
      end else if (a[47:12] == `CTI_CSR_BASE >> 12) begin
        case (a[11:0])
          `CTI_OFS_SW_TRIG: decode = A_SWT;
          `CTI_OFS_TRIG_CTRL: decode = A_TRIG;
          default: decode = A_NONE;
        endcase
      end
    end
  endfunction

  // format acceptance per variant
  function fmt_ok;
    input [7:0] f;
    begin
      if (COLOR)
        fmt_ok = (f == `CTI_FMT_MONO8) || (f == `CTI_FMT_RAW8) ||
                 (f == `CTI_FMT_RAW16) || (f == `CTI_FMT_YUV422); // R14
      else
        fmt_ok = (f == `CTI_FMT_MONO8) || (f == `CTI_FMT_MONO16); // R14
    end
  endfunction

  reg [15:0] org_x_q, org_y_q, wid_q, hgt_q, pay_q;
  reg [7:0] fmt_q;
  reg trig_en_q, trig_pol_q, trig_mode_q, sw_trig_q;
  reg [2:0] trig_src_q;
  reg [3:0] pin_s1_q, pin_s2_q;
  reg lvl_prev_q;
  reg [31:0] div_q_q, pkt_q;
  reg [16:0] div_r_q;
  reg [5:0] div_cnt_q;
  reg [15:0] div_d_q;

  wire [4:0] sel = decode(quad_addr);
  wire wr = quad_req & quad_write;
  wire [15:0] w_hi = quad_wdata[31:16] & ~(UNIT - 16'h0001); // R10
  wire [15:0] w_lo = quad_wdata[15:0] & ~(UNIT - 16'h0001);
  wire [15:0] p_hi = quad_wdata[31:16] & ~(UNIT - 16'h0001); // R11
  wire [15:0] p_lo = quad_wdata[15:0] & ~(UNIT - 16'h0001);

  // derived frame quantities
  wire [31:0] pix_count = wid_q * hgt_q; // R16
  wire wide_fmt = (fmt_q == `CTI_FMT_MONO16) || (fmt_q == `CTI_FMT_RAW16) ||
                  (fmt_q == `CTI_FMT_YUV422);
  wire [31:0] raw_bytes = (wide_fmt ? {pix_count[30:0], 1'b0} : pix_count) + EXTRA_BYTES;
  wire [31:0] frame_bytes = (raw_bytes + 32'h0000_0003) & 32'hffff_fffc; // R17
  wire [15:0] ceiling = (frame_bytes < {16'h0000, `CTI_PAYLOAD_SUGGESTED}) ?
                        frame_bytes[15:0] : `CTI_PAYLOAD_SUGGESTED; // R18
  // payload may exceed a ceiling that shrank after a later ROI write
  wire [15:0] pay_eff = (pay_q > ceiling) ? ceiling : pay_q;
  wire [7:0] depth_eff = (wide_fmt && fmt_q != `CTI_FMT_YUV422) ? 8'h0a : 8'h08; // R21
  wire [7:0] depth_tx = wide_fmt ? 8'h10 : 8'h08; // R21

  // trigger level from the selected pin, after polarity
  wire pin_sel = pin_s2_q[trig_src_q[1:0]]; // R3
  wire lvl = trig_pol_q ? pin_sel : ~pin_sel; // R2
  wire sw_src = (trig_src_q == `CTI_SRC_SOFTWARE);
  wire act_lvl = sw_src ? sw_trig_q : lvl;
  wire sw_set = wr && sel == A_SWT && quad_wdata[`CTI_SW_TRIG_BIT];

  // register writes
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      org_x_q <= 16'h0000; // R12
      org_y_q <= 16'h0000; // R12
      wid_q <= `CTI_HMAX; // R12
      hgt_q <= VMAX; // R12
      fmt_q <= FMT_RST; // R13
      pay_q <= `CTI_PAYLOAD_SUGGESTED;
      trig_en_q <= `CTI_TRIG_EN_RST; // R1
      trig_pol_q <= `CTI_TRIG_POL_RST; // R2
      trig_src_q <= `CTI_TRIG_SRC_RST; // R3
      trig_mode_q <= `CTI_TRIG_MODE_RST; // R4
    end else if (wr) begin
      case (sel)
        // origin and extent must keep the ROI inside the sensor
        A_ORIG: begin
          if ({1'b0, p_hi} + {1'b0, wid_q} <= {1'b0, `CTI_HMAX} &&
              {1'b0, p_lo} + {1'b0, hgt_q} <= {1'b0, VMAX}) begin
            org_x_q <= p_hi;
            org_y_q <= p_lo;
          end
        end
        A_EXT: begin
          if (w_hi != 16'h0000 && w_lo != 16'h0000 &&
              {1'b0, org_x_q} + {1'b0, w_hi} <= {1'b0, `CTI_HMAX} &&
              {1'b0, org_y_q} + {1'b0, w_lo} <= {1'b0, VMAX}) begin
            wid_q <= w_hi;
            hgt_q <= w_lo;
          end
        end
        A_FMT: if (fmt_ok(quad_wdata[31:24])) fmt_q <= quad_wdata[31:24]; // R14
        A_PAY: begin
          if ((quad_wdata[31:16] & 16'hfffc) >= `CTI_PAYLOAD_GRANULE)
            pay_q <= quad_wdata[31:16] & 16'hfffc; // R18
        end
        A_TRIG: begin
          trig_en_q <= quad_wdata[`CTI_TRIG_EN_BIT]; // R1
          trig_pol_q <= quad_wdata[`CTI_TRIG_POL_BIT]; // R2
          // unsupported sources 4..6 leave the selection as it was
          if (quad_wdata[23] == 1'b0 || quad_wdata[23:21] == `CTI_SRC_SOFTWARE)
            trig_src_q <= quad_wdata[23:21]; // R3
          if (quad_wdata[19:17] == 3'h0)
            trig_mode_q <= quad_wdata[`CTI_TRIG_MODE_BIT]; // R4
          // bits 11:0 (parameter) are never stored R6
        end
        default: ;
      endcase
    end
  end

  // software trigger flag; a new write of 1 wins over the self-clear
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      sw_trig_q <= 1'b0;
    else if (sw_set)
      sw_trig_q <= 1'b1; // R7
    else if (wr && sel == A_SWT)
      sw_trig_q <= 1'b0;
    else if (sw_trig_q && !trig_mode_q)
      sw_trig_q <= 1'b0; // R7
  end

  // pin synchroniser; only the second stage feeds logic
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      lvl_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= external_trigger_input;
      pin_s2_q <= pin_s1_q;
      lvl_prev_q <= act_lvl;
    end
  end

  // exposure control: edge starts, level mode also gates duration
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      exposure_start <= 1'b0;
      exposure_gate <= 1'b0;
      trigger_in_use <= 1'b0;
    end else begin
      trigger_in_use <= trig_en_q; // R1
      exposure_start <= trig_en_q & act_lvl & ~lvl_prev_q; // R4
      // software source with level mode is a host error; gate follows the flag R5
      exposure_gate <= trig_en_q & trig_mode_q & act_lvl; // R4
    end
  end

  // packets per frame: ceil(bytes / payload), one restoring step per cycle
  // serial divider trades 33 cycles of latency for no wide divider
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_q <= 6'h00;
      div_q_q <= 32'h0000_0000;
      div_r_q <= 17'h0_0000;
      div_d_q <= `CTI_PAYLOAD_SUGGESTED;
      pkt_q <= 32'h0000_0000;
    end else if (div_cnt_q == 6'h00) begin
      div_q_q <= frame_bytes + {16'h0000, pay_eff} - 32'h0000_0001; // R19
      div_d_q <= pay_eff;
      div_r_q <= 17'h0_0000;
      div_cnt_q <= 6'h20;
    end else begin
      if ({div_r_q[15:0], div_q_q[31]} >= {1'b0, div_d_q}) begin
        div_r_q <= {div_r_q[15:0], div_q_q[31]} - {1'b0, div_d_q};
        div_q_q <= {div_q_q[30:0], 1'b1};
      end else begin
        div_r_q <= {div_r_q[15:0], div_q_q[31]};
        div_q_q <= {div_q_q[30:0], 1'b0};
      end
      div_cnt_q <= div_cnt_q - 6'h01;
      if (div_cnt_q == 6'h01 && div_d_q != 16'h0000)
        pkt_q <= (({div_r_q[15:0], div_q_q[31]} >= {1'b0, div_d_q}) ?
                  {div_q_q[30:0], 1'b1} : {div_q_q[30:0], 1'b0}); // R19
    end
  end

  // quadlet answers: one cycle after the request
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      quad_ack <= 1'b0;
      quad_err <= 1'b0;
      quad_rdata <= 32'h0000_0000;
    end else begin
      quad_ack <= quad_req;
      quad_err <= quad_req & (sel == A_NONE);
      quad_rdata <= 32'h0000_0000;
      if (quad_req && !quad_write) begin
        case (sel)
          A_MAX: quad_rdata <= {`CTI_HMAX, VMAX}; // R8
          A_SSTEP: quad_rdata <= {UNIT, UNIT}; // R10
          A_ORIG: quad_rdata <= {org_x_q, org_y_q};
          A_EXT: quad_rdata <= {wid_q, hgt_q};
          A_FMT: quad_rdata <= {fmt_q, 24'h00_0000};
          A_CAPS: quad_rdata <= COLOR ? 32'ha060_0000 : 32'h8400_0000; // R14
          A_CAPS2: quad_rdata <= 32'h0000_0000; // R15
          A_PIX: quad_rdata <= pix_count; // R16
          A_BHI: quad_rdata <= 32'h0000_0000; // R17
          A_BLO: quad_rdata <= frame_bytes; // R17
          A_PLIM: quad_rdata <= {`CTI_PAYLOAD_GRANULE, ceiling}; // R18
          A_PAY: quad_rdata <= {pay_eff, `CTI_PAYLOAD_SUGGESTED}; // R18
          A_PKT: quad_rdata <= pkt_q; // R19
          A_PSTEP: quad_rdata <= {UNIT, UNIT}; // R11
          A_BITS: quad_rdata <= {depth_eff, depth_tx, 16'h0000}; // R21
          A_MOS: quad_rdata <= {MOSAIC_ORDER[7:0], 24'h00_0000}; // R22
          A_SWT: quad_rdata <= {sw_trig_q, 31'h0000_0000}; // R7
          A_TRIG: quad_rdata <= {1'b1, 5'h00, trig_en_q, trig_pol_q, trig_src_q,
                                 act_lvl, 3'h0, trig_mode_q, 16'h0000};
          default: quad_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // mirror of the active settings for the sensor and packetiser
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      roi_left <= 16'h0000;
      roi_top <= 16'h0000;
      roi_width <= `CTI_HMAX;
      roi_height <= VMAX;
      vga_left <= 16'h0000;
      vga_top <= 16'h0000;
      pixel_format <= FMT_RST;
      payload_setting <= `CTI_PAYLOAD_SUGGESTED;
      frame_packets <= 32'h0000_0000;
    end else begin
      roi_left <= org_x_q;
      roi_top <= org_y_q;
      roi_width <= wid_q;
      roi_height <= hgt_q;
      vga_left <= (`CTI_HMAX - `CTI_VGA_W) >> 1; // R9
      vga_top <= (VMAX - `CTI_VGA_H) >> 1; // R9
      pixel_format <= fmt_q;
      payload_setting <= pay_eff;
      frame_packets <= pkt_q;
    end
  end

endmodule

// [testbench/cti_regs_chk.sv]
// concurrent checks on the trigger and roi register block
// bound to cti_regs; sees only its ports, one clock domain
`timescale 1ns/10ps
`include "cti_map.vh"
module cti_regs_chk #(
  parameter COLOR = 0,
  parameter MOSAIC_ORDER = 0,
  parameter EXTRA_BYTES = 0
) (
  input wire clk,
  input wire reset_n,
  input wire quad_req,
  input wire quad_write,
  input wire [47:0] quad_addr,
  input wire [31:0] quad_wdata,
  input wire quad_ack,
  input wire quad_err,
  input wire [31:0] quad_rdata,
  input wire [3:0] external_trigger_input,
  input wire exposure_start,
  input wire exposure_gate,
  input wire trigger_in_use,
  input wire [15:0] roi_left,
  input wire [15:0] roi_top,
  input wire [15:0] roi_width,
  input wire [15:0] roi_height,
  input wire [15:0] vga_left,
  input wire [15:0] vga_top,
  input wire [7:0] pixel_format,
  input wire [15:0] payload_setting,
  input wire [31:0] frame_packets
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // format write decode; legality depends on the variant
  wire fmt_wr = quad_req && quad_write && quad_addr == `CTI_M0_BASE + `CTI_OFS_FMT_SEL;
  function automatic logic legal(input logic [7:0] f);
    if (COLOR) return f == 8'h00 || f == 8'h09 || f == 8'h0a || f == 8'h02;
    return f == 8'h00 || f == 8'h05;
  endfunction
  // a lone legal write, not overtaken by a second one
  sequence s_fmt_take;
    fmt_wr && legal(quad_wdata[31:24]) ##1 !fmt_wr;
  endsequence
  sequence s_off3;
    !trigger_in_use [*3];
  endsequence
  AST_ACK_ONE: assert property (quad_req |=> quad_ack)
    else $error("request not answered next cycle");
  AST_ACK_CAUSE: assert property (quad_ack |-> $past(quad_req))
    else $error("answer without request");
  AST_ERR_ACK: assert property (quad_err |-> quad_ack)
    else $error("error flag outside answer");
  AST_RDATA_IDLE: assert property (!quad_ack |-> quad_rdata == 32'h0)
    else $error("read data outside answer");
  AST_TRIG_OFF: assert property (s_off3 |-> !exposure_start && !exposure_gate)
    else $error("exposure while trigger off");
  AST_START_PULSE: assert property (exposure_start |=> !exposure_start)
    else $error("start longer than one cycle");
  AST_VGA: assert property ($past(reset_n, 3) |->
    vga_left == 16'h0008 && vga_top == 16'h0005)
    else $error("vga offset not centred");
  AST_EXT_STABLE: assert property (
    !$past(quad_ack) |-> $stable(roi_width) && $stable(roi_height))
    else $error("extent moved without a write");
  AST_FMT_LEGAL: assert property (legal(pixel_format))
    else $error("unsupported format active");
  AST_FMT_TAKE: assert property (s_fmt_take |=> pixel_format == $past(quad_wdata[31:24], 2))
    else $error("legal format not taken");
  AST_RST_VALS: assert property ($rose(reset_n) |-> roi_width == `CTI_HMAX
    && roi_left == 16'h0 && roi_height == (COLOR ? 16'h01ea : 16'h01eb)
    && pixel_format == (COLOR ? 8'h02 : 8'h00) && payload_setting == 16'h0ffc)
    else $error("wrong value after reset");
endmodule
bind cti_regs cti_regs_chk #(.COLOR(COLOR), .MOSAIC_ORDER(MOSAIC_ORDER),
  .EXTRA_BYTES(EXTRA_BYTES)) cti_regs_chk_inst (.clk, .reset_n, .quad_req, .quad_write,
  .quad_addr, .quad_wdata, .quad_ack, .quad_err, .quad_rdata, .external_trigger_input,
  .exposure_start, .exposure_gate, .trigger_in_use, .roi_left, .roi_top, .roi_width,
  .roi_height, .vga_left, .vga_top, .pixel_format, .payload_setting, .frame_packets);

// [testbench/cti_host_model.sv]
// host model issuing single quadlet requests to the camera registers
// assumes the bench calls its task from one process at a time
`timescale 1ns/10ps
module cti_host_model (
  input wire clk,
  input wire quad_ack,
  input wire quad_err,
  input wire [31:0] quad_rdata,
  output logic quad_req = 1'b0,
  output logic quad_write = 1'b0,
  output logic [47:0] quad_addr = 48'h0,
  output logic [31:0] quad_wdata = 32'h0
);
  logic ok;
  // one-cycle request; the answer is awaited for a few edges only
  task xfer(input logic w, input logic [47:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    ok = 1'b0;
    q = 32'h0;
    e = 1'b0;
    @(posedge clk);
    quad_req <= 1'b1;
    quad_write <= w;
    quad_addr <= a;
    quad_wdata <= d;
    @(posedge clk);
    quad_req <= 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      if (quad_ack === 1'b1) begin
        ok = 1'b1;
        q = quad_rdata;
        e = quad_err;
      end
    end
  endtask
  // software source is never paired with level mode
  function logic [31:0] trig_word(input logic on, pol, input logic [2:0] src,
    input logic md, input logic [11:0] par);
    return {6'h0, on, pol, src, 4'h0, (src == 3'h7) ? 1'b0 : md, 4'h0, par};
  endfunction
endmodule

// [testbench/cti_regs_tb_top.sv]
// self-checking bench for the trigger and roi registers, mono variant on the bus
// a colour variant shares the bus inputs; only its roi top, roi height and format mirrors are watched
// host model drives requests; bench drives trigger pins and reset
`timescale 1ns/10ps
`include "cti_map.vh"
module cti_regs_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] pins = 4'h0;
  wire quad_req, quad_write, quad_ack, quad_err, exposure_start, exposure_gate, trigger_in_use;
  wire [47:0] quad_addr;
  wire [31:0] quad_wdata, quad_rdata, frame_packets;
  wire [15:0] roi_left, roi_top, roi_width, roi_height, vga_left, vga_top, payload_setting;
  wire [7:0] pixel_format;
  wire [15:0] c_top, c_height;
  wire [7:0] c_format;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [31:0] q;
  logic e;
  localparam logic [47:0] IMG = `CTI_M0_BASE;
  localparam logic [47:0] TRG = `CTI_CSR_BASE + `CTI_OFS_TRIG_CTRL;
  localparam logic [47:0] SWT = `CTI_CSR_BASE + `CTI_OFS_SW_TRIG;
  always #2 clk = ~clk;
  cti_regs #(.COLOR(0), .MOSAIC_ORDER(2), .EXTRA_BYTES(0)) cti_regs_inst (.clk, .reset_n,
    .quad_req, .quad_write, .quad_addr, .quad_wdata, .quad_ack, .quad_err, .quad_rdata,
    .external_trigger_input(pins), .exposure_start, .exposure_gate, .trigger_in_use,
    .roi_left, .roi_top, .roi_width, .roi_height, .vga_left, .vga_top, .pixel_format,
    .payload_setting, .frame_packets);
  // colour variant sees every host write; its answers are left unconnected
  cti_regs #(.COLOR(1), .MOSAIC_ORDER(1), .EXTRA_BYTES(0)) cti_regs_color_inst (.clk,
    .reset_n, .quad_req, .quad_write, .quad_addr, .quad_wdata, .quad_ack(), .quad_err(),
    .quad_rdata(), .external_trigger_input(pins), .exposure_start(), .exposure_gate(),
    .trigger_in_use(), .roi_left(), .roi_top(c_top), .roi_width(), .roi_height(c_height),
    .vga_left(), .vga_top(), .pixel_format(c_format), .payload_setting(), .frame_packets());
  cti_host_model cti_host_model_inst (.clk, .quad_ack, .quad_err, .quad_rdata, .quad_req,
    .quad_write, .quad_addr, .quad_wdata);
  task conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // a lost answer ends the run, later checks would be meaningless
  task acc(input logic w, input logic [47:0] a, input logic [31:0] d);
    cti_host_model_inst.xfer(w, a, d, q, e);
    if (!cti_host_model_inst.ok) begin
      n_mismatch++;
      $display("[FAIL] %0t no answer", $time);
      conclude();
    end
  endtask
  task rdc(input logic [47:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task wstart(output int n);
    n = -1;
    for (int i = 1; i <= 8 && n < 0; i++) begin
      @(posedge clk);
      if (exposure_start === 1'b1) n = i;
    end
  endtask
  task t_reset();
    logic [11:0] oa [16];
    logic [31:0] ov [16];
    oa = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h024, 12'h034,
      12'h038, 12'h03c, 12'h040, 12'h044, 12'h048, 12'h04c, 12'h054, 12'h058};
    ov = '{32'h0290_01eb, 32'h0001_0001, 32'h0, 32'h0290_01eb, 32'h0, 32'h8400_0000, 32'h0,
      32'h0004_ea30, 32'h0, 32'h0004_ea30, 32'h0004_0ffc, 32'h0ffc_0ffc, 32'h0000_004f,
      32'h0001_0001, 32'h0808_0000, 32'h0200_0000};
    for (int i = 0; i < 16; i++) begin
      rdc(IMG + oa[i], ov[i]);
    end
    acc(1'b0, IMG + 12'h050, 32'h0);
    chk(e, 1'b1);
    acc(1'b1, IMG, 32'h0);
    rdc(IMG, 32'h0290_01eb);
    acc(1'b0, TRG, 32'h0);
    chk(q & 32'hffef_ffff, 32'h8001_0000);
    chk({c_height, c_format}, {16'h01ea, 8'h02});
    $display("t_reset done");
  endtask
  task t_roi();
    acc(1'b1, IMG + `CTI_OFS_EXTENT, 32'h0280_01e0);
    acc(1'b1, IMG + `CTI_OFS_ORIGIN, 32'h0010_000b);
    acc(1'b1, IMG + `CTI_OFS_FMT_SEL, {`CTI_FMT_MONO16, 24'h0});
    acc(1'b1, IMG + `CTI_OFS_FMT_SEL, {`CTI_FMT_RAW8, 24'h0});
    rdc(IMG + `CTI_OFS_PIX_COUNT, 32'h0004_b000);
    rdc(IMG + `CTI_OFS_BYTES_LO, 32'h0009_6000);
    rdc(IMG + `CTI_OFS_BIT_COUNT, 32'h0a10_0000);
    chk({roi_left, roi_width}, 32'h0010_0280);
    chk({roi_top, roi_height}, 32'h000b_01e0);
    chk({c_top, c_format}, {16'h000a, 8'h09});
    chk(pixel_format, 8'h05);
    // a divider pass already under way uses old values, so allow two passes
    repeat (70) @(posedge clk);
    rdc(IMG + `CTI_OFS_PKT_COUNT, 32'h0000_0097);
    // host keeps packets per frame far below 4095
    acc(1'b1, IMG + `CTI_OFS_PAYLOAD, 32'h0800_0000);
    repeat (70) @(posedge clk);
    rdc(IMG + `CTI_OFS_PKT_COUNT, 32'h0000_012c);
    rdc(IMG + `CTI_OFS_PAYLOAD, 32'h0800_0ffc);
    chk(payload_setting, 16'h0800);
    chk(frame_packets, 32'h0000_012c);
    $display("t_roi done");
  endtask
  task t_ext();
    int n;
    acc(1'b1, TRG, cti_host_model_inst.trig_word(1'b1, 1'b1, 3'h1, 1'b1, 12'hfff));
    acc(1'b0, TRG, 32'h0);
    chk(q & 32'hffef_ffff, 32'h8321_0000);
    @(posedge clk) pins <= 4'h1;
    wstart(n);
    chk(n, -1);
    @(posedge clk) pins <= 4'h3;
    wstart(n);
    chk(n > 0, 1'b1);
    chk({trigger_in_use, exposure_gate}, 2'b11);
    @(posedge clk) pins <= 4'h2;
    acc(1'b1, TRG, cti_host_model_inst.trig_word(1'b1, 1'b0, 3'h1, 1'b1, 12'h0));
    @(posedge clk) pins <= 4'h0;
    wstart(n);
    chk(n > 0, 1'b1);
    $display("t_ext done");
  endtask
  task t_sw();
    int n;
    acc(1'b1, TRG, cti_host_model_inst.trig_word(1'b1, 1'b0, 3'h7, 1'b1, 12'h0));
    acc(1'b0, TRG, 32'h0);
    chk(q & 32'hffef_ffff, 32'h82e0_0000);
    acc(1'b1, SWT, 32'h8000_0000);
    wstart(n);
    chk(n > 0, 1'b1);
    rdc(SWT, 32'h0);
    acc(1'b1, TRG, cti_host_model_inst.trig_word(1'b1, 1'b0, 3'h5, 1'b0, 12'h0));
    acc(1'b0, TRG, 32'h0);
    chk(q & 32'hffef_ffff, 32'h82e0_0000);
    acc(1'b1, TRG, cti_host_model_inst.trig_word(1'b0, 1'b0, 3'h7, 1'b0, 12'h0));
    acc(1'b1, SWT, 32'h8000_0000);
    wstart(n);
    chk(n, -1);
    chk(trigger_in_use, 1'b0);
    $display("t_sw done");
  endtask
  // reset for four cycles, then let the packet divider settle
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (40) @(posedge clk);
    t_reset();
    t_roi();
    t_ext();
    t_sw();
    conclude();
  end
endmodule
